// ---- core/ddrcp_core.sv ----
/*
  DDR2 command protocol core: decodes commands, tracks four banks,
  applies additive latency, runs bursts on a single-rate data path.
  Assumes a synchronous controller on CLOCK that obeys its own timing.
*/
// Contract
// RULE1: Chip select high ignores command pins
// RULE2: All strobes high is a no-operation
// RULE3: Mode load: bank selects register, address data
// RULE4: Controller loads modes only when banks idle
// RULE5: Activate opens addressed row until precharge
// RULE6: Controller precharges before new row
// RULE7: Read bursts from column A0-A8
// RULE8: Write bursts into column A0-A8
// RULE9: A10 selects auto precharge after burst
// RULE10: Additive latency delays internal read/write
// RULE11: Mask high beats leave bytes unchanged
// RULE12: Precharge closes one bank or all
// RULE13: Controller waits tRP before activate
// RULE14: Other-bank access allowed during auto precharge
// RULE15: Controller activates before read or write
// RULE16: Precharge on idle bank restarts timer
// RULE17: Controller refreshes only with banks idle
// RULE18: Refresh uses internal row address only
// RULE19: Refresh with clock enable low enters self refresh
// RULE20: DLL off in self refresh, on after
// RULE21: Termination follows input, never in self refresh
// RULE22: Controller holds clock enable around extended load
// RULE23: Decode commands from sampled strobes, clock enable
// RULE24: Controller self refreshes only when idle
// RULE25: Controller sends idle commands after exit
// RULE26: Track per-bank open state and row
module ddrcp_core #(
  parameter int unsigned BURST = ddrcp_pkg::BURST_LEN
) (
  input  wire logic                                CLOCK,
  input  wire logic                                RST,
  input  wire ddrcp_pkg::ddrcp_cmd_s               CMD,
  input  wire logic                                ODT_IN,
  input  wire logic [ddrcp_pkg::DATA_W-1:0]        WDATA,
  input  wire logic [ddrcp_pkg::MASK_W-1:0]        WMASK,
  output      logic [ddrcp_pkg::DATA_W-1:0]        RDATA,
  output      logic                                RVALID,
  output      logic [ddrcp_pkg::BANKS-1:0]         BANK_OPEN,
  output      logic [ddrcp_pkg::BANKS-1:0]         BANK_READY,
  output      logic                                DLL_ON,
  output      logic                                ODT_ON,
  output      logic                                SELF_REFRESH,
  output      logic                                CMD_ERROR,
  output      logic [ddrcp_pkg::ADDR_W-1:0]        MODE_REG,
  output      logic [ddrcp_pkg::ADDR_W-1:0]        EXT_MODE_REG,
  output      logic [ddrcp_pkg::ROW_W-1:0]         REFRESH_ROW
);

  initial
  begin
    if (BURST < 1 || BURST > 8)
      $error("ddrcp_core burst length out of range");
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic ddrcp_pkg::ddrcp_cmd_e decode(input ddrcp_pkg::ddrcp_cmd_s c);
    if (c.cs_n)
      decode = ddrcp_pkg::CMD_DESELECT;                         // [RULE1]
    else
      case ({c.ras_n, c.cas_n, c.we_n})                         // [RULE23]
        3'b111:  decode = ddrcp_pkg::CMD_NOP;                   // [RULE2]
        3'b000:  decode = ddrcp_pkg::CMD_MODE_LOAD;
        3'b001:  decode = c.cke ? ddrcp_pkg::CMD_REFRESH : ddrcp_pkg::CMD_SELF_REFRESH;
        3'b010:  decode = ddrcp_pkg::CMD_PRECHARGE;
        3'b011:  decode = ddrcp_pkg::CMD_ACTIVATE;
        3'b100:  decode = ddrcp_pkg::CMD_WRITE;
        3'b101:  decode = ddrcp_pkg::CMD_READ;
        default: decode = ddrcp_pkg::CMD_ILLEGAL;
      endcase
  endfunction

  function automatic logic [ddrcp_pkg::MEM_AW-1:0] mem_addr(
    input logic [ddrcp_pkg::BA_W-1:0] b, input logic [ddrcp_pkg::COL_W-1:0] c);
    mem_addr = {b, c[ddrcp_pkg::MEM_AW-ddrcp_pkg::BA_W-1:0]};
  endfunction

  ddrcp_pkg::ddrcp_cmd_e   cmd;
  ddrcp_pkg::ddrcp_state_e state;
  logic                    cke_prev;
  logic                    live;
  ddrcp_pkg::ddrcp_bank_s  bank [ddrcp_pkg::BANKS];
  logic [ddrcp_pkg::TIMER_W-1:0] rp_cnt [ddrcp_pkg::BANKS];
  logic [ddrcp_pkg::AL_W-1:0] additive_latency;

  // Only a clock-enabled cycle in normal state executes a command
  assign live = (state == ddrcp_pkg::ST_NORMAL) && cke_prev;
  always_comb cmd = live ? decode(CMD) : ddrcp_pkg::CMD_NOP;

  // ****************************************************************
  // Power state, DLL and termination
  // ****************************************************************
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state        <= ddrcp_pkg::ST_NORMAL;
      cke_prev     <= 1'b1;
      SELF_REFRESH <= 1'b0;
      DLL_ON       <= 1'b1;
    end
    else
    begin
      cke_prev <= CMD.cke;
      case (state)
        ddrcp_pkg::ST_NORMAL:
          if (cmd == ddrcp_pkg::CMD_SELF_REFRESH)               // [RULE19]
          begin
            state        <= ddrcp_pkg::ST_SELF_REFRESH;
            SELF_REFRESH <= 1'b1;
            DLL_ON       <= 1'b0;                               // [RULE20]
          end
        ddrcp_pkg::ST_SELF_REFRESH:
          if (CMD.cke)
          begin
            state        <= ddrcp_pkg::ST_NORMAL;
            SELF_REFRESH <= 1'b0;
            DLL_ON       <= 1'b1;                               // [RULE20]
          end
        default: state <= ddrcp_pkg::ST_NORMAL;
      endcase
    end
  end

  logic odt_cfg;
  assign odt_cfg = EXT_MODE_REG[ddrcp_pkg::MR_ODT_B0] | EXT_MODE_REG[ddrcp_pkg::MR_ODT_B1];

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      ODT_ON <= 1'b0;
    else
      ODT_ON <= odt_cfg && ODT_IN && (state == ddrcp_pkg::ST_NORMAL)
                && !(cmd == ddrcp_pkg::CMD_SELF_REFRESH);       // [RULE21]
  end

  // ****************************************************************
  // Mode registers and refresh counter
  // ****************************************************************
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      MODE_REG         <= ddrcp_pkg::ADDR_ZERO;
      EXT_MODE_REG     <= ddrcp_pkg::ADDR_ZERO;
      additive_latency <= '0;
    end
    else if (cmd == ddrcp_pkg::CMD_MODE_LOAD)
    begin
      if (CMD.ba == ddrcp_pkg::MR_SEL_MODE)                     // [RULE3]
        MODE_REG <= CMD.addr;
      else if (CMD.ba == ddrcp_pkg::MR_SEL_EXT1)
      begin
        EXT_MODE_REG     <= CMD.addr;
        additive_latency <= (CMD.addr[ddrcp_pkg::MR_AL_LSB +: ddrcp_pkg::AL_W]
                             > ddrcp_pkg::AL_W'(ddrcp_pkg::AL_MAX))
                            ? ddrcp_pkg::AL_W'(ddrcp_pkg::AL_MAX)
                            : CMD.addr[ddrcp_pkg::MR_AL_LSB +: ddrcp_pkg::AL_W];
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      REFRESH_ROW <= '0;
    else if (cmd == ddrcp_pkg::CMD_REFRESH || cmd == ddrcp_pkg::CMD_SELF_REFRESH)
      REFRESH_ROW <= REFRESH_ROW + 1'b1;                        // [RULE18]
  end

  // ****************************************************************
  // Additive latency line for reads and writes
  // ****************************************************************
  // Entry: valid, write, auto precharge, bank, column
  localparam int unsigned ENT_W = 3 + ddrcp_pkg::BA_W + ddrcp_pkg::COL_W;
  logic [ENT_W-1:0] al_line [ddrcp_pkg::AL_MAX+1];
  logic [ENT_W-1:0] issued;
  logic [ENT_W-1:0] due;
  logic             rw_cmd;

  assign rw_cmd = (cmd == ddrcp_pkg::CMD_READ) || (cmd == ddrcp_pkg::CMD_WRITE);
  assign issued = {rw_cmd, cmd == ddrcp_pkg::CMD_WRITE, CMD.addr[ddrcp_pkg::AP_BIT],
                   CMD.ba, CMD.addr[ddrcp_pkg::COL_W-1:0]};     // [RULE7] [RULE8] [RULE9]

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      for (int i = 0; i <= ddrcp_pkg::AL_MAX; i++)
        al_line[i] <= '0;
    else
    begin
      al_line[0] <= issued;
      for (int i = 1; i <= ddrcp_pkg::AL_MAX; i++)
        al_line[i] <= al_line[i-1];
    end
  end

  // Zero latency takes the command itself; otherwise tap the line
  always_comb
    due = (additive_latency == '0) ? issued : al_line[additive_latency - 1'b1]; // [RULE10]

  // ****************************************************************
  // Burst engine
  // ****************************************************************
  logic                          b_act;
  logic                          b_wr;
  logic                          b_ap;
  logic [ddrcp_pkg::BA_W-1:0]    b_bank;
  logic [ddrcp_pkg::COL_W-1:0]   b_col;
  logic [3:0]                    b_cnt;
  logic                          b_last;
  logic                          rd_pend;
  logic [ddrcp_pkg::DATA_W-1:0]  mem_q;

  assign b_last = b_act && (b_cnt == 4'(BURST - 1));

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      b_act  <= 1'b0;
      b_wr   <= 1'b0;
      b_ap   <= 1'b0;
      b_bank <= '0;
      b_col  <= '0;
      b_cnt  <= '0;
    end
    else if (due[ENT_W-1])
    begin
      b_act  <= 1'b1;
      b_wr   <= due[ENT_W-2];
      b_ap   <= due[ENT_W-3];
      b_bank <= due[ddrcp_pkg::COL_W +: ddrcp_pkg::BA_W];
      b_col  <= due[ddrcp_pkg::COL_W-1:0];
      b_cnt  <= '0;
    end
    else if (b_act)
    begin
      b_act <= !b_last;
      b_col <= b_col + 1'b1;
      b_cnt <= b_cnt + 1'b1;
    end
  end

  ddrcp_mem #(
    .AW (ddrcp_pkg::MEM_AW),
    .DW (ddrcp_pkg::DATA_W),
    .MW (ddrcp_pkg::MASK_W)
  ) u_mem (
    .CLOCK (CLOCK),
    .we    (b_act && b_wr),
    .mask  (WMASK),                                             // [RULE11]
    .waddr (mem_addr(b_bank, b_col)),
    .wdata (WDATA),
    .raddr (mem_addr(b_bank, b_col)),
    .rdata (mem_q)
  );

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      rd_pend <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= '0;
    end
    else
    begin
      rd_pend <= b_act && !b_wr;
      RVALID  <= rd_pend;
      RDATA   <= mem_q;
    end
  end

  // ****************************************************************
  // Bank state and precharge timing
  // ****************************************************************
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      for (int b = 0; b < ddrcp_pkg::BANKS; b++)
      begin
        bank[b]   <= '0;
        rp_cnt[b] <= '0;
      end
    else
      for (int b = 0; b < ddrcp_pkg::BANKS; b++)
      begin
        if (rp_cnt[b] != '0)
          rp_cnt[b] <= rp_cnt[b] - 1'b1;
        if (cmd == ddrcp_pkg::CMD_ACTIVATE && CMD.ba == ddrcp_pkg::BA_W'(b))
          bank[b] <= '{open: 1'b1, row: CMD.addr};              // [RULE5] [RULE26]
        // Other banks keep working while this one auto precharges
        if (b_last && b_ap && b_bank == ddrcp_pkg::BA_W'(b))    // [RULE9] [RULE14]
        begin
          bank[b].open <= 1'b0;
          rp_cnt[b]    <= ddrcp_pkg::TIMER_W'(ddrcp_pkg::TRP_CYC);
        end
        if (cmd == ddrcp_pkg::CMD_PRECHARGE &&
            (CMD.addr[ddrcp_pkg::AP_BIT] || CMD.ba == ddrcp_pkg::BA_W'(b))) // [RULE12]
        begin
          bank[b].open <= 1'b0;
          rp_cnt[b]    <= ddrcp_pkg::TIMER_W'(ddrcp_pkg::TRP_CYC); // [RULE16]
        end
      end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      BANK_OPEN  <= '0;
      BANK_READY <= '1;
    end
    else
      for (int b = 0; b < ddrcp_pkg::BANKS; b++)
      begin
        BANK_OPEN[b]  <= bank[b].open;
        BANK_READY[b] <= !bank[b].open && rp_cnt[b] == '0;
      end
  end

  // ****************************************************************
  // Legality check against tracked bank state
  // ****************************************************************
  logic                        any_open;
  logic [ddrcp_pkg::BANKS-1:0] open_vec;
  always_comb
  begin
    any_open = 1'b0;
    open_vec = '0;
    for (int b = 0; b < ddrcp_pkg::BANKS; b++)
    begin
      any_open    = any_open | bank[b].open;
      open_vec[b] = bank[b].open;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      CMD_ERROR <= 1'b0;
    else
      case (cmd)                                                // [RULE26]
        ddrcp_pkg::CMD_ACTIVATE:
          CMD_ERROR <= bank[CMD.ba].open || rp_cnt[CMD.ba] != '0;
        ddrcp_pkg::CMD_READ, ddrcp_pkg::CMD_WRITE:
          CMD_ERROR <= !bank[CMD.ba].open;
        ddrcp_pkg::CMD_MODE_LOAD, ddrcp_pkg::CMD_REFRESH,
        ddrcp_pkg::CMD_SELF_REFRESH:
          CMD_ERROR <= any_open;
        ddrcp_pkg::CMD_ILLEGAL:
          CMD_ERROR <= 1'b1;
        default:
          CMD_ERROR <= 1'b0;
      endcase
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_sr_entry;
    !RST && live && !CMD.cs_n && !CMD.ras_n && !CMD.cas_n && CMD.we_n && !CMD.cke;
  endsequence

  AST_DESELECT_NO_BANK_CHANGE: assert property (@(posedge CLOCK) disable iff (RST) // [RULE1]
    (cmd == ddrcp_pkg::CMD_DESELECT && !b_last) |=> $stable(open_vec))
    else $error("deselect changed bank state");

  AST_NOP_NO_MODE_CHANGE: assert property (@(posedge CLOCK) disable iff (RST) // [RULE2]
    (!CMD.cs_n && CMD.ras_n && CMD.cas_n && CMD.we_n) |=> $stable(MODE_REG) && $stable(EXT_MODE_REG))
    else $error("nop altered a mode register");

  AST_MODE_LOAD: assert property (@(posedge CLOCK) disable iff (RST) // [RULE3]
    (cmd == ddrcp_pkg::CMD_MODE_LOAD && CMD.ba == ddrcp_pkg::MR_SEL_MODE)
      |=> MODE_REG == $past(CMD.addr))
    else $error("mode register not loaded from address");

  AST_ACTIVATE_OPENS: assert property (@(posedge CLOCK) disable iff (RST) // [RULE5]
    (cmd == ddrcp_pkg::CMD_ACTIVATE) |-> ##2 BANK_OPEN[$past(CMD.ba, 2)])
    else $error("activate did not open bank");

  AST_PRECHARGE_ALL: assert property (@(posedge CLOCK) disable iff (RST) // [RULE12]
    (cmd == ddrcp_pkg::CMD_PRECHARGE && CMD.addr[ddrcp_pkg::AP_BIT]) |-> ##2 BANK_OPEN == '0)
    else $error("precharge all left a bank open");

  AST_AL_DELAY: assert property (@(posedge CLOCK) disable iff (RST) // [RULE10]
    (rw_cmd && additive_latency == 3'h2 && !b_act) |-> ##1 !b_act ##1 !b_act ##1 b_act)
    else $error("additive latency not applied");

  AST_TRP_TIMER: assert property (@(posedge CLOCK) disable iff (RST) // [RULE16]
    (cmd == ddrcp_pkg::CMD_PRECHARGE) |=> rp_cnt[$past(CMD.ba)] == ddrcp_pkg::TIMER_W'(ddrcp_pkg::TRP_CYC))
    else $error("precharge did not restart timer");

  AST_SR_DLL: assert property (@(posedge CLOCK) // [RULE20]
    s_sr_entry |=> !DLL_ON && SELF_REFRESH)
    else $error("dll still on in self refresh");

  AST_ODT_SR: assert property (@(posedge CLOCK) disable iff (RST) // [RULE21]
    SELF_REFRESH |-> !ODT_ON)
    else $error("termination active in self refresh");

  AST_REFRESH_ROW: assert property (@(posedge CLOCK) disable iff (RST) // [RULE18]
    (cmd == ddrcp_pkg::CMD_REFRESH) |=> REFRESH_ROW == $past(REFRESH_ROW) + 1'b1)
    else $error("refresh row not advanced");

endmodule // ddrcp_core

// ---- core/ddrcp_pkg.sv ----
/*
  Package for the DDR2 command protocol block: command pin layouts,
  decoded command set, bank state record and timing constants.
  Assumes a single 200 MHz clock and synchronous command inputs.
*/
package ddrcp_pkg;

  localparam int unsigned BANKS      = 4;
  localparam int unsigned BA_W       = 2;
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned ROW_W      = 13;
  localparam int unsigned COL_W      = 9;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned MASK_W     = 2;
  localparam int unsigned MEM_AW     = 8;
  localparam int unsigned AP_BIT     = 10;
  localparam int unsigned AL_MAX     = 6;
  localparam int unsigned AL_W       = 3;
  localparam int unsigned BURST_LEN  = 4;

  // Mode register fields kept by this block
  localparam int unsigned MR_AL_LSB  = 3;
  localparam int unsigned MR_ODT_B0  = 2;
  localparam int unsigned MR_ODT_B1  = 6;
  localparam logic [BA_W-1:0] MR_SEL_MODE = 2'h0;
  localparam logic [BA_W-1:0] MR_SEL_EXT1 = 2'h1;

  localparam int unsigned CLK_PS      = 5000;
  localparam int unsigned TRP_PS      = 15000;
  localparam int unsigned TRP_CYC     = (TRP_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned TIMER_W     = 4;

  localparam logic [ADDR_W-1:0] ADDR_ZERO = 13'h0000;

  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } ddrcp_cmd_s;

  typedef struct packed {
    logic              open;
    logic [ROW_W-1:0]  row;
  } ddrcp_bank_s;

  typedef enum {
    CMD_DESELECT, CMD_NOP, CMD_MODE_LOAD, CMD_REFRESH, CMD_SELF_REFRESH,
    CMD_PRECHARGE, CMD_ACTIVATE, CMD_WRITE, CMD_READ, CMD_ILLEGAL
  } ddrcp_cmd_e;

  typedef enum {
    ST_NORMAL, ST_SELF_REFRESH
  } ddrcp_state_e;

endpackage

// ---- core/ddrcp_mem.sv ----
/*
  Small synchronous byte-masked memory for the DDR2 command block.
  Assumes one clock; read data is registered.
*/
module ddrcp_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 16,
  parameter int unsigned MW = 2
) (
  input  wire logic          CLOCK,
  input  wire logic          we,
  input  wire logic [MW-1:0] mask,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output      logic [DW-1:0] rdata
);

  initial
  begin
    if (DW != MW * 8)
      $error("ddrcp_mem needs one mask bit per byte");
  end

  logic [DW-1:0] store [2**AW];

  // Masked lanes keep their old byte
  always_ff @(posedge CLOCK)
  begin
    for (int i = 0; i < MW; i++)
    begin
      if (we && !mask[i])
        store[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
    end
  end

  always_ff @(posedge CLOCK)
  begin
    rdata <= store[raddr];
  end

endmodule // ddrcp_mem

// ---- verif/ddrcp_ctl.sv ----
/*
  Controller model for the DDR2 command core: drives commands, write
  beats and the termination request.
  Assumes every task is entered 1 ns after a rising CLOCK edge and
  returns at that same phase.
*/
module ddrcp_ctl
(
  input  wire logic                  CLOCK,
  output      ddrcp_pkg::ddrcp_cmd_s cmd,
  output      logic                  odt,
  output      logic [15:0]           wdata,
  output      logic [1:0]            wmask
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    cmd   = {5'h17, 2'h0, 13'h0000};
    odt   = 1'b0;
    wdata = 16'h0000;
    wmask = 2'h0;
  end

  // ********************
  // Command tasks
  // ********************
  task automatic nop(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge CLOCK);
      #1;
    end
  endtask

  // Pins {cke, cs_n, ras_n, cas_n, we_n}; address inverted after use
  task automatic issue(input logic [4:0] p, input logic [1:0] ba, input logic [12:0] a);
    cmd = {p, ba, a};
    nop(1);
    cmd = {p[4], 4'h7, ~ba, ~a};
  endtask

  // Caller keeps banks idle; cke stays high past the load
  task automatic mrs(input logic [1:0] sel, input logic [12:0] v);
    issue(5'h10, sel, v);
    nop(2);
  endtask

  task automatic pre(input logic [1:0] ba, input logic all);
    issue(5'h12, ba, {2'h0, all, 10'h000});
    nop(int'(ddrcp_pkg::TRP_CYC) + 1);
  endtask

  // Inverted after the burst so a stale beat cannot match
  task automatic beats(input logic [63:0] d, input logic [7:0] m, input int al);
    nop(al);
    for (int i = 0; i < 4; i++)
    begin
      wdata = d[16*i +: 16];
      wmask = m[2*i +: 2];
      nop(1);
    end
    wdata = ~wdata;
    wmask = ~wmask;
  endtask

  task automatic sr_exit();
    issue(5'h17, 2'h0, 13'h0000);
    nop(200);
  endtask

  task automatic term(input logic v);
    odt = v;
  endtask
endmodule // ddrcp_ctl

// ---- verif/tb_top.sv ----
/*
  Self-checking bench for the DDR2 command core, driven through the
  controller model. Assumes single-rate bursts of four beats.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  clock;
  logic                  rst;
  ddrcp_pkg::ddrcp_cmd_s cmd;
  logic                  odt;
  logic [15:0]           wdata;
  logic [1:0]            wmask;
  logic [15:0]           rdata;
  logic                  rvalid;
  logic [3:0]            bank_open;
  logic [3:0]            bank_ready;
  logic                  dll_on;
  logic                  odt_on;
  logic                  self_ref;
  logic                  cmd_error;
  logic [12:0]           mode_reg;
  logic [12:0]           ext_mode_reg;
  logic [12:0]           refresh_row;
  logic [12:0]           r0;
  int                    fails = 0;
  int                    n_checks = 0;
  int                    cyc = 0;
  int                    lat;
  int                    lat0;
  int                    n;

  ddrcp_core i_ddrcp_core (
    .CLOCK        (clock),
    .RST          (rst),
    .CMD          (cmd),
    .ODT_IN       (odt),
    .WDATA        (wdata),
    .WMASK        (wmask),
    .RDATA        (rdata),
    .RVALID       (rvalid),
    .BANK_OPEN    (bank_open),
    .BANK_READY   (bank_ready),
    .DLL_ON       (dll_on),
    .ODT_ON       (odt_on),
    .SELF_REFRESH (self_ref),
    .CMD_ERROR    (cmd_error),
    .MODE_REG     (mode_reg),
    .EXT_MODE_REG (ext_mode_reg),
    .REFRESH_ROW  (refresh_row)
  );

  ddrcp_ctl i_ddrcp_ctl (
    .CLOCK (clock),
    .cmd   (cmd),
    .odt   (odt),
    .wdata (wdata),
    .wmask (wmask)
  );

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ********************
  // Checks and access tasks
  // ********************
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Run is far shorter than this ceiling
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk(16'(got), 16'(exp));
  endtask

  task automatic done(input string s);
    $display("test %s over, mismatches %0d", s, fails);
  endtask

  task automatic act(input logic [1:0] ba, input logic [12:0] row);
    i_ddrcp_ctl.issue(5'h13, ba, row);
  endtask

  task automatic wr(input logic [1:0] ba, input logic [8:0] col, input logic ap,
                    input logic [63:0] d, input logic [7:0] m, input int al);
    i_ddrcp_ctl.issue(5'h14, ba, {2'h0, ap, 1'b0, col});
    i_ddrcp_ctl.beats(d, m, al);
  endtask

  // Cycles from the read to its first beat are left in lat
  task automatic rd(input logic [1:0] ba, input logic [8:0] col, input logic ap,
                    input logic [63:0] e);
    int b = 0;
    lat = -1;
    i_ddrcp_ctl.issue(5'h15, ba, {2'h0, ap, 1'b0, col});
    for (int k = 0; k < 20 && b < 4; k++)
    begin
      if (rvalid === 1'b1)
      begin
        if (b == 0)
          lat = k;
        chk(rdata, e[16*b +: 16]);
        b++;
      end
      i_ddrcp_ctl.nop(1);
    end
    chk(16'(b), 16'h0004);
  endtask

  // ********************
  // Test sequence
  // ********************
  initial
  begin
    rst = 1'b1;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    chk(16'(bank_ready), 16'h000F);
    chk(16'(bank_open), 16'h0000);
    chk1(dll_on, 1'b1);
    done("reset");
    i_ddrcp_ctl.mrs(2'h0, 13'h0A53);
    i_ddrcp_ctl.mrs(2'h1, 13'h0004);
    i_ddrcp_ctl.mrs(2'h2, 13'h1FFF);
    i_ddrcp_ctl.issue(5'h18, 2'h0, 13'h0111);
    i_ddrcp_ctl.nop(2);
    chk(16'(mode_reg), 16'h0A53);
    chk(16'(ext_mode_reg), 16'h0004);
    done("mode");
    act(2'h0, 13'h0123);
    i_ddrcp_ctl.issue(5'h1B, 2'h1, 13'h0456);
    chk(16'(bank_open), 16'h0001);
    i_ddrcp_ctl.nop(1);
    chk(16'(bank_open), 16'h0001);
    i_ddrcp_ctl.nop(1);
    chk(16'(bank_open), 16'h0001);
    act(2'h1, 13'h0456);
    i_ddrcp_ctl.nop(2);
    done("activate");
    wr(2'h0, 9'h004, 1'b0, 64'h4444_3333_2222_1111, 8'h00, 0);
    wr(2'h0, 9'h004, 1'b0, 64'hDDDD_CCCC_BBBB_AAAA, 8'h39, 0);
    rd(2'h0, 9'h004, 1'b0, 64'hDDDD_3333_22BB_AA11);
    lat0 = lat;
    rd(2'h0, 9'h004, 1'b1, 64'hDDDD_3333_22BB_AA11);
    wr(2'h1, 9'h000, 1'b0, 64'h8765_4321_0FED_CBA9, 8'h00, 0);
    rd(2'h1, 9'h000, 1'b0, 64'h8765_4321_0FED_CBA9);
    chk(16'(bank_open), 16'h0002);
    done("burst");
    n = 0;
    i_ddrcp_ctl.issue(5'h15, 2'h0, 13'h0000);
    for (int k = 0; k < 4; k++)
    begin
      n += int'(cmd_error === 1'b1);
      i_ddrcp_ctl.nop(1);
    end
    chk(16'(n), 16'h0001);
    i_ddrcp_ctl.nop(8);
    i_ddrcp_ctl.issue(5'h16, 2'h0, 13'h0000);
    n = int'(cmd_error === 1'b1);
    i_ddrcp_ctl.nop(1);
    chk(16'(n + int'(cmd_error === 1'b1)), 16'h0001);
    done("error");
    act(2'h0, 13'h0077);
    act(2'h2, 13'h0100);
    act(2'h3, 13'h0200);
    i_ddrcp_ctl.pre(2'h1, 1'b0);
    chk(16'(bank_open), 16'h000D);
    i_ddrcp_ctl.issue(5'h12, 2'h0, 13'h0400);
    i_ddrcp_ctl.nop(1);
    i_ddrcp_ctl.issue(5'h12, 2'h0, 13'h0400);
    i_ddrcp_ctl.nop(2);
    chk(16'(bank_ready), 16'h0000);
    chk(16'(bank_open), 16'h0000);
    i_ddrcp_ctl.nop(6);
    chk(16'(bank_ready), 16'h000F);
    done("precharge");
    i_ddrcp_ctl.mrs(2'h1, 13'h0014);
    act(2'h2, 13'h0100);
    wr(2'h2, 9'h008, 1'b0, 64'h0F0F_A5A5_5A5A_F0F0, 8'h00, 2);
    rd(2'h2, 9'h008, 1'b0, 64'h0F0F_A5A5_5A5A_F0F0);
    chk(16'(lat), 16'(lat0 + 2));
    done("latency");
    i_ddrcp_ctl.pre(2'h0, 1'b1);
    r0 = refresh_row;
    i_ddrcp_ctl.issue(5'h11, 2'h3, ~(r0 + 13'h0001));
    i_ddrcp_ctl.nop(4);
    chk(16'(refresh_row), 16'(r0 + 13'h0001));
    done("refresh");
    i_ddrcp_ctl.term(1'b1);
    i_ddrcp_ctl.nop(4);
    chk1(odt_on, 1'b1);
    i_ddrcp_ctl.issue(5'h01, 2'h0, 13'h0000);
    i_ddrcp_ctl.issue(5'h03, 2'h1, 13'h0005);
    i_ddrcp_ctl.nop(3);
    chk1(self_ref, 1'b1);
    chk1(dll_on, 1'b0);
    chk1(odt_on, 1'b0);
    chk(16'(bank_open), 16'h0000);
    i_ddrcp_ctl.sr_exit();
    chk1(self_ref, 1'b0);
    chk1(dll_on, 1'b1);
    chk1(odt_on, 1'b1);
    act(2'h0, 13'h0123);
    rd(2'h0, 9'h004, 1'b0, 64'hDDDD_3333_22BB_AA11);
    done("self refresh");
    conclude();
  end
endmodule // tb_top
